// File: src/acs_adc_control_sequencer.sv
// Functional notes
// - clock-select field picks operating clock
// - sampling field sets sample length
// - cutoff bit closes reference switch
// - continuous bit adds trigger edge as start source
// - writing start bit begins conversion
// - continuous mode starts on rising edges
// - trigger select: pin or timer
// - precision bit: 10-bit or 8-bit
// - channel field indexes sixteen inputs
// - completion flag shows pending request
// - busy flag high during conversion
// - enable bit gates interrupt request
// - writing zero clears completion flag
// - request number 18, vector 0FFD6
// - flag always set; irq needs enable
// - results stored and busy clears on the same edge
// - software start restarts running conversion
// - restart with completion still sets flag
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module acs_adc_control_sequencer
  import acs_pkg::*;
#(
  parameter int RES_BITS = 10
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port: read data stand one cycle after the strobe
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // start sources, taken as synchronous levels
  input  wire logic        external_trigger_pin,
  input  wire logic        composite_timer_output,
  // low power entry; high aborts and holds the sequencer idle
  input  wire logic        stop_or_watch,
  // analog front end: comparator in, mux, switch, sample and trial out
  input  wire logic        comparator_high,
  output logic [3:0]       channel_select,
  output logic             reference_cutoff_switch,
  output logic             sample_hold_en,
  output logic [9:0]       dac_trial,
  output logic             completion_irq
);
  // control register one (channel, cutoff) and two (all config)
  logic [3:0] chan_ff,  nxt_chan;
  logic       cut_ff,   nxt_cut;
  logic [7:0] ctl2_ff,  nxt_ctl2;
  logic       done_ff,  nxt_done;
  logic [9:0] res_ff,   nxt_res;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       irq_ff,   nxt_irq;
  logic       trg_ff,   nxt_trg;

  // sequencer state
  acs_state_t state_ff, nxt_state;
  logic [7:0] div_ff,   nxt_div;
  logic [3:0] cnt_ff,   nxt_cnt;
  logic       samp_ff,  nxt_samp;

  logic       wr_c1, wr_c2, sw_start, hw_start, start, op_tick, finish;
  logic       trig_in;
  logic [7:0] div_limit;
  logic [3:0] samp_len, cmp_len;
  logic       prec8;
  logic [9:0] trial;
  logic [9:0] bit_ptr;
  logic [7:0] ctl1_view;

  assign wr_c1    = reg_wr && (reg_addr == ACS_OFS_CTRL_ONE);
  assign wr_c2    = reg_wr && (reg_addr == ACS_OFS_CTRL_TWO);
  assign prec8    = ctl2_ff[ACS_C2_PREC];
  assign sw_start = wr_c1 && reg_wdata[ACS_C1_START];
  // select trigger source input
  assign trig_in  = ctl2_ff[ACS_C2_TRIG_SEL] ? composite_timer_output
                                             : external_trigger_pin;
  // rising edge only counts in continuous mode
  assign hw_start = ctl2_ff[ACS_C2_CONT] && trig_in && !trg_ff;
  // either source restarts, even mid conversion
  assign start    = (sw_start || hw_start) && !stop_or_watch;

  // operating clock = ref_clk divided by 1,2,4 or 8
  assign div_limit = (ACS_PRESCALE_BASE << ctl2_ff[ACS_C2_CLKSEL_LO +: 2]) - 8'h01;
  assign op_tick   = (div_ff >= div_limit);  // a lowered divider must not wrap
  // sample lengths 1..4 periods from the two-bit field
  assign samp_len  = {2'b00, ctl2_ff[ACS_C2_SAMP_LO +: 2]} + 4'h1;
  assign cmp_len   = prec8 ? 4'(ACS_COMPARE_PERIODS - 2)
                           : 4'(ACS_COMPARE_PERIODS);
  assign finish    = (state_ff == ACS_STORE);

  acs_sar_core #(
    .BITS (RES_BITS)
  ) u_sar (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clear    (start),
    .step     ((state_ff == ACS_COMPARE) && op_tick),
    .cmp_high (comparator_high),
    .trial    (trial),
    .bit_ptr  (bit_ptr)
  );

  // conversion walk in operating periods: start enters sampling,
  // sampling lasts 1..4 periods, comparing ten (eight at 8-bit),
  // one sar step per period, then one store cycle; flags land after it.
  // a restart in any state goes back to sampling and reloads the sar.
  // sequencer next state; stop/watch aborts with busy cleared
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_div   = op_tick ? 8'h00 : div_ff + 8'h01;
    if (stop_or_watch) begin
      nxt_state = ACS_IDLE;
      nxt_div   = 8'h00;
    end else if (start) begin
      nxt_state = ACS_SAMPLE;
      nxt_cnt   = 4'h0;
      nxt_div   = 8'h00;
    end else begin
      case (state_ff)
        ACS_IDLE: begin
          nxt_cnt = 4'h0;
        end
        ACS_SAMPLE: begin
          if (op_tick) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff + 4'h1 == samp_len) begin
              nxt_state = ACS_COMPARE;
              nxt_cnt   = 4'h0;
            end
          end
        end
        ACS_COMPARE: begin
          if (op_tick) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff + 4'h1 == cmp_len) begin
              nxt_state = ACS_STORE;
            end
          end
        end
        ACS_STORE: begin
          nxt_state = ACS_IDLE;
        end
        default: begin
          nxt_state = ACS_IDLE;
        end
      endcase
    end
    // registered copy so the pin comes straight from a flop
    nxt_samp = (nxt_state == ACS_SAMPLE);
  end

  // status view of control register one; start always reads back 0
  always_comb begin
    ctl1_view                      = 8'h00;
    ctl1_view[ACS_C1_CHAN_LO +: 4] = chan_ff;
    ctl1_view[ACS_C1_DONE]         = done_ff;
    ctl1_view[ACS_C1_BUSY]         = (state_ff != ACS_IDLE);
    ctl1_view[ACS_C1_CUTOFF]       = cut_ff;
  end

  // registers, flags and result; result only moves at finish
  always_comb begin
    nxt_chan  = chan_ff;
    nxt_cut   = cut_ff;
    nxt_ctl2  = ctl2_ff;
    nxt_done  = done_ff;
    nxt_res   = res_ff;
    nxt_trg   = trig_in;
    nxt_rdata = 8'h00;
    if (wr_c1) begin
      nxt_chan = reg_wdata[ACS_C1_CHAN_LO +: 4];
      nxt_cut  = reg_wdata[ACS_C1_CUTOFF];
      if (!reg_wdata[ACS_C1_DONE]) begin
        nxt_done = 1'b0;
      end
    end
    if (wr_c2) begin
      nxt_ctl2 = reg_wdata;
    end
    // set beats clear and beats a same-cycle restart
    if (finish) begin
      nxt_done = 1'b1;
      nxt_res  = prec8 ? {2'b00, trial[9:2]} : trial;
    end
    if (reg_rd) begin
      case (reg_addr)
        ACS_OFS_CTRL_ONE: nxt_rdata = ctl1_view;
        ACS_OFS_CTRL_TWO: nxt_rdata = ctl2_ff;
        ACS_OFS_RESULT_HI: nxt_rdata = {6'h00, res_ff[9:8]};
        ACS_OFS_RESULT_LO: nxt_rdata = res_ff[7:0];
        default:          nxt_rdata = 8'h00;
      endcase
    end
    // line to irq controller entry ACS_IRQ_NUMBER, vector ACS_IRQ_VECTOR
    nxt_irq = nxt_done && nxt_ctl2[ACS_C2_IRQ_EN];
  end

  // sequencer registers; reset drops any conversion in flight
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= ACS_IDLE;
      cnt_ff    <= 4'h0;
      div_ff    <= 8'h00;
      samp_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      div_ff    <= nxt_div;
      samp_ff   <= nxt_samp;
    end
  end

  // software visible registers, read data and the request line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_ff   <= ACS_RST_CTRL_ONE[ACS_C1_CHAN_LO +: 4];
      cut_ff    <= ACS_RST_CTRL_ONE[ACS_C1_CUTOFF];
      ctl2_ff   <= ACS_RST_CTRL_TWO;
      done_ff   <= ACS_RST_CTRL_ONE[ACS_C1_DONE];
      res_ff    <= ACS_RST_RESULT;
      rdata_ff  <= 8'h00;
      irq_ff    <= 1'b0;
      trg_ff    <= 1'b0;
    end else begin
      chan_ff   <= nxt_chan;
      cut_ff    <= nxt_cut;
      ctl2_ff   <= nxt_ctl2;
      done_ff   <= nxt_done;
      res_ff    <= nxt_res;
      rdata_ff  <= nxt_rdata;
      irq_ff    <= nxt_irq;
      trg_ff    <= nxt_trg;
    end
  end

  assign reg_rdata               = rdata_ff;
  assign channel_select          = chan_ff;
  assign reference_cutoff_switch = cut_ff;
  assign sample_hold_en          = samp_ff;
  assign dac_trial               = trial;
  assign completion_irq          = irq_ff;
  // bit_ptr kept visible for the core; msb-first walk ends by count
  logic unused_ptr;
  assign unused_ptr = ^bit_ptr;
endmodule
`default_nettype wire

// File: src/acs_pkg.sv
package acs_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] ACS_OFS_CTRL_ONE   = 3'h0;
  localparam logic [2:0] ACS_OFS_CTRL_TWO   = 3'h1;
  localparam logic [2:0] ACS_OFS_RESULT_HI  = 3'h2;
  localparam logic [2:0] ACS_OFS_RESULT_LO  = 3'h3;
  // converter_control_one field positions
  localparam int ACS_C1_START   = 0;
  localparam int ACS_C1_CUTOFF  = 1;
  localparam int ACS_C1_BUSY    = 2;
  localparam int ACS_C1_DONE    = 3;
  localparam int ACS_C1_CHAN_LO = 4;
  // converter_control_two field positions
  localparam int ACS_C2_CLKSEL_LO = 0;
  localparam int ACS_C2_CONT      = 2;
  localparam int ACS_C2_IRQ_EN    = 3;
  localparam int ACS_C2_TRIG_SEL  = 4;
  localparam int ACS_C2_SAMP_LO   = 5;
  localparam int ACS_C2_PREC      = 7;
  // reset values
  localparam logic [7:0] ACS_RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] ACS_RST_CTRL_TWO = 8'h00;
  localparam logic [9:0] ACS_RST_RESULT   = 10'h000;
  // timing: comparison takes ten operating clock periods, eight at 8-bit precision
  localparam int         ACS_COMPARE_PERIODS = 10;
  localparam logic [7:0] ACS_PRESCALE_BASE   = 8'h01;
  // irq routing
  localparam int         ACS_IRQ_NUMBER = 18;
  localparam logic [15:0] ACS_IRQ_VECTOR = 16'hffd6;

  typedef enum logic [1:0] {
    ACS_IDLE    = 2'b00,
    ACS_SAMPLE  = 2'b01,
    ACS_COMPARE = 2'b10,
    ACS_STORE   = 2'b11
  } acs_state_t;
endpackage

// File: src/acs_sar_core.sv
`timescale 1ns/1ps
`default_nettype none
// successive approximation register: one bit decided per step, msb first
module acs_sar_core
  import acs_pkg::*;
#(
  parameter int BITS = 10
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            clear,
  input  wire logic            step,
  input  wire logic            cmp_high,
  output logic [BITS-1:0]      trial,
  output logic [BITS-1:0]      bit_ptr
);
  logic [BITS-1:0] trial_ff;
  logic [BITS-1:0] ptr_ff;
  logic [BITS-1:0] nxt_trial;
  logic [BITS-1:0] nxt_ptr;

  // keep trial bit when comparator says input is above trial level
  always_comb begin
    nxt_trial = trial_ff;
    nxt_ptr   = ptr_ff;
    if (clear) begin
      nxt_ptr   = {1'b1, {(BITS-1){1'b0}}};
      nxt_trial = {1'b1, {(BITS-1){1'b0}}};
    end else if (step && (ptr_ff != '0)) begin
      if (!cmp_high) begin
        nxt_trial = trial_ff & ~ptr_ff;
      end
      nxt_ptr   = ptr_ff >> 1;
      nxt_trial = nxt_trial | (ptr_ff >> 1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trial_ff <= '0;
      ptr_ff   <= '0;
    end else begin
      trial_ff <= nxt_trial;
      ptr_ff   <= nxt_ptr;
    end
  end

  assign trial   = trial_ff;
  assign bit_ptr = ptr_ff;
endmodule
`default_nettype wire

// File: testbench/acs_props.sv
`timescale 1ns/1ps
`default_nettype none
module acs_props
  import acs_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       stop_or_watch,
  input wire logic [3:0] channel_select,
  input wire logic       reference_cutoff_switch,
  input wire logic       sample_hold_en,
  input wire logic       completion_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // bit3 of both control registers can drop the request
  wire logic clr = reg_wr && !reg_wdata[3] && reg_addr <= ACS_OFS_CTRL_TWO;
  wire logic wr1 = reg_wr && reg_addr == ACS_OFS_CTRL_ONE;
  chk_irq_clear: assert property (
    $fell(completion_irq) |-> $past(clr) || $past(clr, 2)) else $error("irq dropped alone");
  chk_start_sample: assert property (
    wr1 && reg_wdata[0] && !stop_or_watch |=> sample_hold_en) else $error("start lost");
  chk_chan_follow: assert property (
    wr1 |=> channel_select == $past(reg_wdata[7:4])) else $error("channel wrong");
  chk_cutoff_follow: assert property (
    wr1 |=> reference_cutoff_switch == $past(reg_wdata[1])) else $error("cutoff wrong");
  chk_stop_idle: assert property (
    stop_or_watch |=> !sample_hold_en) else $error("sampling while stopped");
  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside slot");
  chk_start_reads0: assert property (
    reg_rd && reg_addr == ACS_OFS_CTRL_ONE |=> !reg_rdata[0]) else $error("start bit read 1");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr > ACS_OFS_RESULT_LO |=> reg_rdata == 8'h00) else $error("unmapped");
  chk_high_pad: assert property (
    reg_rd && reg_addr == ACS_OFS_RESULT_HI |=> reg_rdata[7:2] == 6'h00) else $error("pad");
endmodule
`default_nettype wire

// File: testbench/acs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
  input  wire logic [3:0] channel_select,
  input  wire logic [9:0] dac_trial,
  output logic            comparator_high
);
  // each input holds a fixed level named by its index
  assign comparator_high = {channel_select, 6'h2b} >= dac_trial;
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acs_pkg::*;
  logic       ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, exp_q[$], msk_q[$];
  logic       external_trigger_pin = 0, composite_timer_output = 0, stop_or_watch = 0;
  logic       comparator_high, reference_cutoff_switch, sample_hold_en, completion_irq;
  logic [3:0] channel_select, ch;
  logic [9:0] dac_trial;
  logic [1:0] s;
  int         n_errors = 0, cmp_count = 0, seed = 32'h11d0aa28;
  acs_adc_control_sequencer i_acs_adc_control_sequencer (.ref_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .external_trigger_pin, .composite_timer_output,
    .stop_or_watch, .comparator_high, .channel_select, .reference_cutoff_switch,
    .sample_hold_en, .dac_trial, .completion_irq);
  acs_analog_model i_acs_analog_model (.channel_select, .dac_trial, .comparator_high);
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [9:0] lvl(input logic [3:0] c);
    return {c, 6'h2b};
  endfunction
  task test_done;
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task ck(input logic [9:0] g, input logic [9:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: port %h, want %h", $time, g, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // the note goes in before the strobe, the watcher pops it
  task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task wait_irq;
    repeat (300) if (completion_irq !== 1'b1) @(posedge ref_clk);
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_q) begin
      cmp_count++;
      if ((reg_rdata & msk_q[0]) !== exp_q[0]) begin
        n_errors++;
        $display("wrong value at %0t: read %h, want %h", $time, reg_rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_q <= reg_rd;
  end
  initial begin
    #200000;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    // every clock divider, random sampling length and channel
    for (int i = 0; i < 4; i++) begin
      ch = 4'($random(seed));
      s = 2'($random(seed));
      wr(ACS_OFS_CTRL_TWO, {1'b0, s, 2'b01, 1'b0, i[1:0]});
      rd(ACS_OFS_CTRL_TWO, {1'b0, s, 2'b01, 1'b0, i[1:0]});
      wr(ACS_OFS_CTRL_ONE, {ch, 2'b00, i[0], 1'b1});
      ck(channel_select, ch);
      ck(reference_cutoff_switch, i[0]);
      wait_irq;
      ck(completion_irq, 1);
      rd(ACS_OFS_CTRL_ONE, {ch, 2'b10, i[0], 1'b0});
      rd(ACS_OFS_RESULT_HI, lvl(ch) >> 8);
      rd(ACS_OFS_RESULT_LO, lvl(ch));
      wr(ACS_OFS_CTRL_ONE, {ch, 4'b0000});
      rd(ACS_OFS_CTRL_ONE, {ch, 4'b0000});
      ck(completion_irq, 0);
    end
    // no irq enable; restart mid-run; old result seen while busy
    wr(ACS_OFS_CTRL_TWO, 8'h00);
    wr(ACS_OFS_CTRL_ONE, 8'h31);
    rd(ACS_OFS_RESULT_LO, lvl(ch));
    wr(ACS_OFS_CTRL_ONE, 8'h31);
    rd(ACS_OFS_CTRL_ONE, 8'h04, 8'h0c);
    repeat (60) @(posedge ref_clk);
    ck(completion_irq, 0);
    rd(ACS_OFS_CTRL_ONE, 8'h38);
    rd(ACS_OFS_RESULT_LO, lvl(4'h3));
    // restart on the completion edge: set beats the clear it carries
    wr(ACS_OFS_CTRL_ONE, 8'h31);
    repeat (10) @(posedge ref_clk);
    wr(ACS_OFS_CTRL_ONE, 8'h31);
    rd(ACS_OFS_CTRL_ONE, 8'h0c, 8'h0c);
    repeat (20) @(posedge ref_clk);
    // eight bit precision leaves the high result empty
    wr(ACS_OFS_CTRL_TWO, 8'h88);
    wr(ACS_OFS_CTRL_ONE, 8'h51);
    wait_irq;
    rd(ACS_OFS_RESULT_HI, 8'h00);
    rd(ACS_OFS_RESULT_LO, 8'(lvl(4'h5) >> 2));
    wr(ACS_OFS_CTRL_ONE, 8'h50);
    // continuous start: the other source rises first and must do nothing
    for (int t = 0; t < 2; t++) begin
      wr(ACS_OFS_CTRL_TWO, {3'b000, t[0], 4'b1100});
      {external_trigger_pin, composite_timer_output} <= t[0] ? 2'b10 : 2'b01;
      repeat (60) @(posedge ref_clk);
      ck(completion_irq, 0);
      {external_trigger_pin, composite_timer_output} <= 2'b11;
      wait_irq;
      ck(completion_irq, 1);
      {external_trigger_pin, composite_timer_output} <= 2'b00;
      wr(ACS_OFS_CTRL_TWO, 8'h08);
      wr(ACS_OFS_CTRL_ONE, 8'h50);
    end
    // stop mode aborts a running conversion
    wr(ACS_OFS_CTRL_ONE, 8'h51);
    stop_or_watch <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(ACS_OFS_CTRL_ONE, 8'h00, 8'h04);
    stop_or_watch <= 1'b0;
    // let the watcher take the last read before the verdict
    @(posedge ref_clk);
    test_done;
  end
endmodule
bind acs_adc_control_sequencer acs_props i_acs_props (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .stop_or_watch, .channel_select, .reference_cutoff_switch,
  .sample_hold_en, .completion_irq);
`default_nettype wire
